// ---- src/ssp_pkg.sv ----
/*
  shared constants and types for the clock-stop serial port.
  assumes: included before every other file of the block.
*/
package ssp_pkg;

  // clock-stop mode encodings
  localparam logic [1:0] SSP_CSTOP_NODELAY = 2'h2;
  localparam logic [1:0] SSP_CSTOP_DELAY = 2'h3;

  // rate generator setting that slave operation needs
  localparam logic SSP_SLAVE_SRC_SEL = 1'h1;
  localparam int SSP_DIV_W = 8;
  localparam logic [SSP_DIV_W-1:0] SSP_SLAVE_DIV = 8'h01;

  // structure defaults
  localparam int SSP_DATA_W = 16;
  localparam int SSP_FIFO_DEPTH = 32;
  localparam int SSP_SYNC_STAGES = 2;

  // positions in the synchronised pin vector
  localparam int SSP_PIN_TXC = 4;
  localparam int SSP_PIN_TXF = 3;
  localparam int SSP_PIN_RXC = 2;
  localparam int SSP_PIN_RXF = 1;
  localparam int SSP_PIN_DIN = 0;
  localparam int SSP_PIN_N = 5;

  // reset values: select pins rest high, so no false select edge after reset
  localparam logic [SSP_PIN_N-1:0] SSP_PIN_RST = 5'h0a;

  typedef struct packed {
    logic [1:0] clock_stop_mode;
    logic transmit_clock_polarity;
    logic rx_sync_polarity;
    logic tx_sync_polarity;
    logic tx_clock_direction;
    logic tx_sync_direction;
    logic rx_clock_direction;
    logic rx_sync_direction;
    logic rate_gen_source_select;
    logic [SSP_DIV_W-1:0] rate_gen_divider;
  } ssp_cfg_t;

  typedef enum logic [3:0] {
    SSP_ST_IDLE = 4'h1,
    SSP_ST_SHIFT = 4'h2,
    SSP_ST_TRAIL = 4'h4,
    SSP_ST_SLAVE = 4'h8
  } ssp_state_t;

endpackage : ssp_pkg

// ---- src/ssp_fifo.sv ----
/*
  transmit word fifo with valid/ready on both sides.
  assumes: one clock, synchronous active-low reset.
*/
`timescale 1ns/10ps
`default_nettype none
module ssp_fifo #(
  parameter int W = 16,
  parameter int DEPTH = 32
) (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
      $error("fifo depth must be a power of two of at least 2");
    end
  endgenerate

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;

  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  assign in_ready = (count_reg != (AW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign out_data = mem[rd_ptr_reg];

  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_reg + AW'(push);
      rd_ptr_reg <= rd_ptr_reg + AW'(pop);
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : ssp_fifo
`default_nettype wire

// ---- src/ssp_rate_gen.sv ----
/*
  serial clock phase timer for master operation.
  assumes: run is held for the whole transfer; counts restart when it drops.
*/
`timescale 1ns/10ps
`default_nettype none
module ssp_rate_gen #(
  parameter int DIV_W = 8
) (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // control
  input wire logic run,
  input wire logic [DIV_W-1:0] divider,
  // phase ends
  output logic lead_tick,
  output logic trail_tick
);
  generate
    if (DIV_W < 1) begin : g_bad_div
      $error("divider width must be at least 1");
    end
  endgenerate

  logic [DIV_W:0] cnt_reg;
  logic high_reg;

  // low phase: half of divider+1 when odd, divider/2 when even, one cycle when zero
  function automatic logic [DIV_W:0] low_len(input logic [DIV_W-1:0] d);
    logic [DIV_W:0] n;
    n = {1'b0, d};
    if (d == '0) begin
      low_len = (DIV_W+1)'(1);
    end else if (d[0]) begin
      low_len = (n + (DIV_W+1)'(1)) >> 1;
    end else begin
      low_len = n >> 1;
    end
  endfunction : low_len

  // high phase: equal halves when odd, divider/2+1 when even
  function automatic logic [DIV_W:0] high_len(input logic [DIV_W-1:0] d);
    logic [DIV_W:0] n;
    n = {1'b0, d};
    if (d[0]) begin
      high_len = (n + (DIV_W+1)'(1)) >> 1;
    end else begin
      high_len = (n >> 1) + (DIV_W+1)'(1);
    end
  endfunction : high_len

  wire [DIV_W:0] phase_len = high_reg ? high_len(divider) : low_len(divider);
  wire phase_end = run && (cnt_reg == phase_len - (DIV_W+1)'(1));

  assign lead_tick = phase_end && !high_reg;
  assign trail_tick = phase_end && high_reg;

  always_ff @(posedge clock) begin
    if (!resetn || !run) begin
      cnt_reg <= '0;
      high_reg <= 1'b0;
    end else if (phase_end) begin
      cnt_reg <= '0;
      high_reg <= !high_reg;
    end else begin
      cnt_reg <= cnt_reg + (DIV_W+1)'(1);
    end
  end
endmodule : ssp_rate_gen
`default_nettype wire

// ---- src/ssp_spi_port.sv ----
/*
  clock-stop (spi style) serial port, master or slave.
  assumes: pins arrive asynchronously and are synchronised here;
  the caller resolves pin levels from the *_oe_n outputs.
*/
// Functional notes
// - mode 10, idle low: launch rise, sample fall
// - mode 11, idle low: launch early, sample rise
// - mode 10, idle high: launch fall, sample rise
// - mode 11, idle high: launch early, sample fall
// - master select output inverted, active low
// - slave inverts active-low select inputs
// - master drives transmit clock and sync
// - slave takes all clocks and syncs
// - clock period is divider plus one cycles, two for divider zero
// - low phase follows divider parity
// - high phase follows divider parity
// - select leads first edge by low phase
// - select held one period after last edge
// - slave drives first bit on select
// - slave data tri-stated when select drops
`timescale 1ns/10ps
`default_nettype none
module ssp_spi_port
  import ssp_pkg::*;
#(
  parameter int DATA_W = SSP_DATA_W,
  parameter int FIFO_DEPTH = SSP_FIFO_DEPTH
) (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // configuration
  input wire ssp_pkg::ssp_cfg_t cfg,
  // transmit word stream
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [DATA_W-1:0] tx_data,
  // received words
  output logic rx_valid,
  output logic [DATA_W-1:0] rx_data,
  // status
  output logic busy,
  output logic config_error,
  // transmit clock pin
  input wire logic transmit_serial_clock_in,
  output logic transmit_serial_clock_out,
  output logic transmit_serial_clock_oe_n,
  // transmit frame sync pin
  input wire logic transmit_frame_sync_in,
  output logic transmit_frame_sync_out,
  output logic transmit_frame_sync_oe_n,
  // receive pins
  input wire logic receive_serial_clock,
  input wire logic receive_frame_sync,
  // data pins
  input wire logic serial_data_in,
  output logic serial_data_out,
  output logic serial_data_oe_n
);
  import ssp_pkg::*;

  localparam int CNT_W = $clog2(DATA_W + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(DATA_W - 1);
  localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DATA_W);

  generate
    if (DATA_W < 2 || DATA_W > 32) begin : g_bad_width
      $error("word width must lie between 2 and 32");
    end
  endgenerate

  // pin synchroniser: two stages, then an edge history stage
  logic [SSP_PIN_N-1:0] pin_meta_reg;
  logic [SSP_PIN_N-1:0] pin_sync_reg;
  logic [SSP_PIN_N-1:0] pin_prev_reg;

  wire [SSP_PIN_N-1:0] pin_raw = {transmit_serial_clock_in, transmit_frame_sync_in,
    receive_serial_clock, receive_frame_sync, serial_data_in};

  always_ff @(posedge clock) begin
    if (!resetn) begin
      pin_meta_reg <= SSP_PIN_RST;
      pin_sync_reg <= SSP_PIN_RST;
      pin_prev_reg <= SSP_PIN_RST;
    end else begin
      pin_meta_reg <= pin_raw;
      pin_sync_reg <= pin_meta_reg;
      pin_prev_reg <= pin_sync_reg;
    end
  end

  // mode decode
  wire pol = cfg.transmit_clock_polarity;
  wire is_cstop = (cfg.clock_stop_mode == SSP_CSTOP_NODELAY) ||
    (cfg.clock_stop_mode == SSP_CSTOP_DELAY);
  wire delay_mode = (cfg.clock_stop_mode == SSP_CSTOP_DELAY);
  wire dir_master = cfg.tx_clock_direction && cfg.tx_sync_direction &&
    !cfg.rx_clock_direction && !cfg.rx_sync_direction;
  wire dir_slave = !cfg.tx_clock_direction && !cfg.tx_sync_direction &&
    !cfg.rx_clock_direction && !cfg.rx_sync_direction;
  wire slave_rate_ok = (cfg.rate_gen_source_select == SSP_SLAVE_SRC_SEL) &&
    (cfg.rate_gen_divider == SSP_SLAVE_DIV);
  wire cfg_ok = is_cstop && (dir_master || (dir_slave && slave_rate_ok));
  wire go_master = cfg_ok && dir_master;
  wire go_slave = cfg_ok && dir_slave;

  // clock edges normalised so the leading edge leaves the idle level
  wire txc_now = pin_sync_reg[SSP_PIN_TXC] ^ pol;
  wire txc_old = pin_prev_reg[SSP_PIN_TXC] ^ pol;
  wire rxc_now = pin_sync_reg[SSP_PIN_RXC] ^ pol;
  wire rxc_old = pin_prev_reg[SSP_PIN_RXC] ^ pol;
  wire tx_lead_edge = txc_now && !txc_old;
  wire tx_trail_edge = !txc_now && txc_old;
  wire rx_lead_edge = rxc_now && !rxc_old;
  wire rx_trail_edge = !rxc_now && rxc_old;

  // active-low select inputs turned into active-high selects
  wire sel_now = (cfg.tx_sync_polarity ? !pin_sync_reg[SSP_PIN_TXF] :
    pin_sync_reg[SSP_PIN_TXF]) && (cfg.rx_sync_polarity ?
    !pin_sync_reg[SSP_PIN_RXF] : pin_sync_reg[SSP_PIN_RXF]);
  wire sel_old = (cfg.tx_sync_polarity ? !pin_prev_reg[SSP_PIN_TXF] :
    pin_prev_reg[SSP_PIN_TXF]) && (cfg.rx_sync_polarity ?
    !pin_prev_reg[SSP_PIN_RXF] : pin_prev_reg[SSP_PIN_RXF]);
  wire sel_rise = sel_now && !sel_old;
  wire sel_fall = !sel_now && sel_old;
  wire din = pin_sync_reg[SSP_PIN_DIN];

  // transmit fifo
  logic fifo_valid;
  logic fifo_pop;
  logic [DATA_W-1:0] fifo_data;

  ssp_fifo #(
    .W(DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clock(clock),
    .resetn(resetn),
    .in_valid(tx_valid),
    .in_ready(tx_ready),
    .in_data(tx_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_data)
  );

  // engine state
  ssp_state_t state_reg;
  ssp_state_t state_next;
  logic [DATA_W-1:0] tx_shift_reg;
  logic [DATA_W-1:0] tx_shift_next;
  logic [DATA_W-1:0] rx_shift_reg;
  logic [DATA_W-1:0] rx_shift_next;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic first_reg;
  logic first_next;
  logic act_reg;
  logic act_next;
  logic clk_level_next;
  logic dout_next;
  logic doe_n_next;
  logic [DATA_W-1:0] rx_data_next;
  logic rx_valid_next;

  // master clock timer
  logic lead_tick;
  logic trail_tick;
  wire gen_run = (state_reg == SSP_ST_SHIFT) || (state_reg == SSP_ST_TRAIL);

  ssp_rate_gen #(
    .DIV_W(SSP_DIV_W)
  ) u_rate_gen (
    .clock(clock),
    .resetn(resetn),
    .run(gen_run),
    .divider(cfg.rate_gen_divider),
    .lead_tick(lead_tick),
    .trail_tick(trail_tick)
  );

  // launch and sample points per mode
  wire m_last = delay_mode ? (cnt_reg == CNT_FULL) : (cnt_reg == CNT_LAST);
  wire m_launch = delay_mode ? (trail_tick && !m_last) : lead_tick;
  wire m_sample = delay_mode ? lead_tick : trail_tick;
  wire s_launch = delay_mode ? tx_trail_edge : (tx_lead_edge && !first_reg);
  wire s_sample = delay_mode ? rx_lead_edge : rx_trail_edge;
  wire in_slave = (state_reg == SSP_ST_SLAVE);
  wire do_launch = (state_reg == SSP_ST_SHIFT) ? m_launch : (in_slave && s_launch);
  wire do_sample = (state_reg == SSP_ST_SHIFT) ? m_sample : (in_slave && s_sample);
  wire [DATA_W-1:0] rx_shifted = {rx_shift_reg[DATA_W-2:0], din};
  wire [DATA_W-1:0] slave_word = fifo_valid ? fifo_data : '0;
  wire [DATA_W-1:0] load_word = go_master ? fifo_data : slave_word;

  always_comb begin
    state_next = state_reg;
    tx_shift_next = tx_shift_reg;
    rx_shift_next = rx_shift_reg;
    cnt_next = cnt_reg;
    first_next = first_reg;
    act_next = act_reg;
    clk_level_next = transmit_serial_clock_out;
    dout_next = serial_data_out;
    doe_n_next = serial_data_oe_n;
    rx_data_next = rx_data;
    rx_valid_next = 1'b0;
    fifo_pop = 1'b0;
    if (do_launch) begin
      dout_next = tx_shift_reg[DATA_W-1];
      tx_shift_next = {tx_shift_reg[DATA_W-2:0], 1'b0};
      doe_n_next = 1'b0;
    end
    if (do_sample) begin
      rx_shift_next = rx_shifted;
      cnt_next = cnt_reg + CNT_W'(1);
      if (cnt_reg == CNT_LAST) begin
        rx_data_next = rx_shifted;
        rx_valid_next = 1'b1;
        if (in_slave) begin
          cnt_next = '0;
        end
      end
    end
    case (state_reg)
      SSP_ST_IDLE: begin
        clk_level_next = pol;
        doe_n_next = 1'b1;
        act_next = 1'b0;
        cnt_next = '0;
        first_next = 1'b1;
        if ((go_master && fifo_valid) || (go_slave && sel_rise)) begin
          fifo_pop = fifo_valid;
          act_next = go_master;
          tx_shift_next = load_word;
          state_next = go_master ? SSP_ST_SHIFT : SSP_ST_SLAVE;
          if (delay_mode || go_slave) begin
            dout_next = load_word[DATA_W-1];
            tx_shift_next = {load_word[DATA_W-2:0], 1'b0};
            doe_n_next = 1'b0;
          end
        end
      end
      SSP_ST_SHIFT: begin
        if (lead_tick) begin
          clk_level_next = !pol;
        end
        if (trail_tick) begin
          clk_level_next = pol;
          if (m_last) begin
            state_next = SSP_ST_TRAIL;
          end
        end
      end
      SSP_ST_TRAIL: begin
        if (lead_tick) begin
          doe_n_next = 1'b1;
        end
        if (trail_tick) begin
          act_next = 1'b0;
          state_next = SSP_ST_IDLE;
        end
      end
      SSP_ST_SLAVE: begin
        if (tx_lead_edge) begin
          first_next = 1'b0;
        end
        if (sel_fall || !go_slave) begin
          doe_n_next = 1'b1;
          state_next = SSP_ST_IDLE;
        end
      end
      default: begin
        state_next = SSP_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      state_reg <= SSP_ST_IDLE;
      tx_shift_reg <= '0;
      rx_shift_reg <= '0;
      cnt_reg <= '0;
      first_reg <= 1'b1;
      act_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      tx_shift_reg <= tx_shift_next;
      rx_shift_reg <= rx_shift_next;
      cnt_reg <= cnt_next;
      first_reg <= first_next;
      act_reg <= act_next;
    end
  end

  // registered pin and status outputs
  always_ff @(posedge clock) begin
    if (!resetn) begin
      transmit_serial_clock_out <= 1'b0;
      transmit_serial_clock_oe_n <= 1'b1;
      transmit_frame_sync_out <= 1'b0;
      transmit_frame_sync_oe_n <= 1'b1;
      serial_data_out <= 1'b0;
      serial_data_oe_n <= 1'b1;
      rx_data <= '0;
      rx_valid <= 1'b0;
      busy <= 1'b0;
      config_error <= 1'b0;
    end else begin
      transmit_serial_clock_out <= clk_level_next;
      transmit_serial_clock_oe_n <= !go_master;
      transmit_frame_sync_out <= act_next ^ cfg.tx_sync_polarity;
      transmit_frame_sync_oe_n <= !go_master;
      serial_data_out <= dout_next;
      serial_data_oe_n <= doe_n_next;
      rx_data <= rx_data_next;
      rx_valid <= rx_valid_next;
      busy <= (state_next != SSP_ST_IDLE);
      config_error <= !cfg_ok;
    end
  end
endmodule : ssp_spi_port
`default_nettype wire

// ---- testbench/ssp_spi_sva.sv ----
/*
  assertion checker for the clock-stop serial port, bound to its top module.
  assumes: one clock domain, synchronous active-low reset, active-low selects.
*/
`timescale 1ns/10ps
`default_nettype none
module ssp_spi_sva
  import ssp_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // configuration and status
  input wire ssp_pkg::ssp_cfg_t cfg,
  input wire logic busy,
  input wire logic config_error,
  // pins
  input wire logic transmit_serial_clock_out,
  input wire logic transmit_serial_clock_oe_n,
  input wire logic transmit_frame_sync_in,
  input wire logic transmit_frame_sync_out,
  input wire logic transmit_frame_sync_oe_n,
  input wire logic receive_frame_sync,
  input wire logic serial_data_oe_n
);
  import ssp_pkg::*;
  logic [8:0] idle_cnt_reg;
  wire logic [3:0] dirs = {cfg.tx_clock_direction, cfg.tx_sync_direction,
    cfg.rx_clock_direction, cfg.rx_sync_direction};
  wire logic mst = dirs == 4'hc && cfg.clock_stop_mode[1];
  wire logic slv = dirs == 4'h0 && cfg.clock_stop_mode[1] && cfg.tx_sync_polarity
    && cfg.rx_sync_polarity;
  wire logic lead = transmit_serial_clock_out != cfg.transmit_clock_polarity;
  wire logic act = transmit_frame_sync_out ^ cfg.tx_sync_polarity;
  wire logic sel_in = !transmit_frame_sync_in && !receive_frame_sync;
  wire logic [8:0] period = {1'b0, cfg.rate_gen_divider} + 9'h001;

  // idle-level cycles while the select is active
  always_ff @(posedge clock) begin
    if (!resetn || !act || lead)
      idle_cnt_reg <= 9'h000;
    else
      idle_cnt_reg <= idle_cnt_reg + 9'h001;
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  sequence s_lead_three;
    lead[*3] ##1 !lead;
  endsequence
  sequence s_lead_four;
    lead[*4] ##1 !lead;
  endsequence
  sequence s_first_edge;
    (!lead)[*3] ##1 lead;
  endsequence

  a_master_pins: assert property ((mst && $stable(cfg)) |=>
    !transmit_serial_clock_oe_n && !transmit_frame_sync_oe_n && !config_error)
    else $error("master pins not driven");
  a_slave_pins: assert property ((slv && $stable(cfg)) |=>
    transmit_serial_clock_oe_n && transmit_frame_sync_oe_n)
    else $error("slave drives clock or sync");
  a_slave_divider: assert property ((slv && $stable(cfg) && cfg.rate_gen_divider != 8'h01)
    |=> config_error) else $error("bad slave divider not flagged");
  a_clock_idle: assert property ((!busy && !transmit_serial_clock_oe_n && $stable(cfg))
    ##1 (!busy && $stable(cfg)) |-> !lead) else $error("clock not at idle level");
  a_select_lead: assert property (($rose(act) && busy && !transmit_frame_sync_oe_n
    && cfg.rate_gen_divider inside {8'h05, 8'h06}) |-> s_first_edge)
    else $error("select lead wrong");
  a_lead_odd: assert property (($rose(lead) && busy && $stable(cfg)
    && cfg.rate_gen_divider == 8'h05) |-> s_lead_three) else $error("odd phase wrong");
  a_lead_even: assert property (($rose(lead) && busy && $stable(cfg)
    && cfg.rate_gen_divider == 8'h06) |-> s_lead_four) else $error("even phase wrong");
  a_select_hold: assert property (($fell(act) && $past(busy) && !transmit_frame_sync_oe_n)
    |-> idle_cnt_reg == period) else $error("select hold wrong");
  a_select_active: assert property (($rose(lead) && busy && !transmit_frame_sync_oe_n)
    |-> transmit_frame_sync_out == !cfg.tx_sync_polarity) else $error("select level wrong");
  a_slave_drive: assert property ((slv && $rose(sel_in)) |-> ##[1:6] !serial_data_oe_n)
    else $error("slave data not driven");
  a_slave_release: assert property ((slv && $fell(sel_in)) |-> ##[1:6] serial_data_oe_n)
    else $error("slave data not released");
endmodule : ssp_spi_sva

bind ssp_spi_port ssp_spi_sva i_sva (.clock, .resetn, .cfg, .busy, .config_error,
  .transmit_serial_clock_out, .transmit_serial_clock_oe_n, .transmit_frame_sync_in,
  .transmit_frame_sync_out, .transmit_frame_sync_oe_n, .receive_frame_sync,
  .serial_data_oe_n);
`default_nettype wire

// ---- testbench/ssp_spi_peer.sv ----
/*
  far-side spi slave model for the port in master use.
  assumes: select active low; pol and dly follow the port's settings.
*/
`timescale 1ns/10ps
`default_nettype none
module ssp_spi_peer (
  // serial pins
  input wire logic sclk,
  input wire logic sel_n,
  input wire logic mosi,
  output logic miso,
  // mode and reply word
  input wire logic pol,
  input wire logic dly,
  input wire logic [15:0] w
);
  logic [15:0] sh;
  logic [15:0] got_q[$];
  int i;
  initial miso = 1'b0;
  // delay modes put the first bit out on select
  always @(negedge sel_n) begin
    i = 0;
    if (dly) begin
      miso = w[15];
      i = 1;
    end
  end
  // launch on one edge, sample on the other
  always @(sclk) begin
    if (sel_n === 1'b0) begin
      if ((sclk != pol) ^ dly) begin
        if (i < 16) miso = w[15 - i];
        i++;
      end else begin
        sh = {sh[14:0], mosi};
      end
    end
  end
  // released line shows the inverse of the last bit
  always @(posedge sel_n) begin
    got_q.push_back(sh);
    miso = ~miso;
  end
endmodule : ssp_spi_peer
`default_nettype wire

// ---- testbench/ssp_spi_port_bench.sv ----
/*
  self-checking bench for the clock-stop serial port.
  assumes: peer model as spi slave; bench plays the master in slave tests.
*/
`timescale 1ns/10ps
`default_nettype none
module ssp_spi_port_bench;
  import ssp_pkg::*;
  logic clock, resetn, tx_valid, m_clk, m_sel;
  logic [15:0] tx_data, peer_word;
  ssp_cfg_t cfg;
  wire logic tx_ready, rx_valid, busy, config_error, tsc_out, tsc_oe_n;
  wire logic tfs_out, tfs_oe_n, sdo, sdo_oe_n, sdi;
  wire logic [15:0] rx_data;
  wire logic tsc = tsc_oe_n ? m_clk : tsc_out;
  wire logic tfs = tfs_oe_n ? m_sel : tfs_out;
  wire logic mosi = sdo_oe_n ? ~sdo : sdo;
  int miscompares, checks_done, n;

  ssp_spi_port i_dut (.clock, .resetn, .cfg, .tx_valid, .tx_ready, .tx_data,
    .rx_valid, .rx_data, .busy, .config_error, .transmit_serial_clock_in(tsc),
    .transmit_serial_clock_out(tsc_out), .transmit_serial_clock_oe_n(tsc_oe_n),
    .transmit_frame_sync_in(tfs), .transmit_frame_sync_out(tfs_out),
    .transmit_frame_sync_oe_n(tfs_oe_n), .receive_serial_clock(tsc),
    .receive_frame_sync(tfs), .serial_data_in(sdi), .serial_data_out(sdo),
    .serial_data_oe_n(sdo_oe_n));
  ssp_spi_peer i_peer (.sclk(tsc), .sel_n(tfs), .mosi, .miso(sdi),
    .pol(cfg.transmit_clock_polarity), .dly(cfg.clock_stop_mode[0]), .w(peer_word));

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  task tick;
    @(posedge clock);
    #2;
  endtask : tick
  task chk_word(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: word %h, expected %h", $time, got, exp);
    end
  endtask : chk_word
  task chk_bit(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: flag %b, expected %b", $time, got, exp);
    end
  endtask : chk_bit
  function ssp_cfg_t mk(input logic [1:0] mode, input logic pol, input logic mst,
    input logic [7:0] div);
    mk = '{mode, pol, 1'b1, 1'b1, mst, mst, 1'b0, 1'b0, !mst, div};
  endfunction : mk
  task push(input logic [15:0] d);
    tx_valid = 1'b1;
    tx_data = d;
    for (n = 0; n < 50 && tx_ready !== 1'b1; n++) tick;
    tick;
  endtask : push
  task rx_word(input logic [15:0] exp);
    for (n = 0; n < 400 && rx_valid !== 1'b1; n++) tick;
    chk_word(rx_data, exp);
    tick;
  endtask : rx_word
  task idle_wait;
    for (n = 0; n < 400 && busy !== 1'b0; n++) tick;
    repeat (2) tick;
  endtask : idle_wait
  // bench as master: select, 16 clock periods of 16 cycles, release
  task slave_xfer(input logic [15:0] exp_rx, input logic [15:0] exp_tx);
    logic [15:0] got;
    got = 16'h0000;
    i_peer.got_q.delete();
    m_sel = 1'b0;
    repeat (8) tick;
    for (int e = 0; e < 32; e++) begin
      m_clk = ~m_clk;
      for (int c = 0; c < 8; c++) begin
        tick;
        if (rx_valid === 1'b1) got = rx_data;
      end
    end
    m_sel = 1'b1;
    repeat (8) tick;
    chk_word(got, exp_rx);
    chk_word(i_peer.got_q[0], exp_tx);
  endtask : slave_xfer
  task wrap_up;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up

  // whole run is about 4400 cycles
  initial begin
    repeat (20000) @(posedge clock);
    miscompares++;
    wrap_up;
  end

  initial begin
    resetn = 1'b0;
    tx_valid = 1'b0;
    tx_data = 16'h0000;
    m_clk = 1'b0;
    m_sel = 1'b1;
    peer_word = 16'h0000;
    cfg = mk(2'h2, 1'b0, 1'b1, 8'h05);
    miscompares = 0;
    checks_done = 0;
    repeat (20) tick;
    resetn = 1'b1;
    repeat (4) tick;
    // four modes, odd and even divider
    for (int k = 0; k < 4; k++) begin
      cfg = mk({1'b1, k[0]}, k[1], 1'b1, k[0] ? 8'h06 : 8'h05);
      peer_word = 16'hc3a5 ^ {12'h000, k[3:0]};
      repeat (4) tick;
      i_peer.got_q.delete();
      push(16'h8e17 ^ {k[3:0], 12'h000});
      tx_valid = 1'b0;
      rx_word(peer_word);
      idle_wait;
      chk_word(i_peer.got_q[0], 16'h8e17 ^ {k[3:0], 12'h000});
    end
    // fill while stopped, then drain
    cfg = mk(2'h0, 1'b0, 1'b1, 8'h06);
    repeat (3) tick;
    chk_bit(config_error, 1'b1);
    for (int i = 0; i < 32; i++) push({i[7:0], ~i[7:0]});
    tx_data = 16'hdead;
    repeat (3) tick;
    chk_bit(tx_ready, 1'b0);
    tx_valid = 1'b0;
    peer_word = 16'h5a0f;
    i_peer.got_q.delete();
    // clock pin parked at the new idle level so the first select sees no edge
    m_clk = 1'b1;
    cfg = mk(2'h3, 1'b1, 1'b1, 8'h05);
    for (int i = 0; i < 32; i++) rx_word(peer_word);
    idle_wait;
    chk_bit(tx_ready, 1'b1);
    for (int i = 0; i < 32; i++) chk_word(i_peer.got_q[i], {i[7:0], ~i[7:0]});
    // slave: bench selects the port, clock held still
    m_clk = 1'b0;
    cfg = mk(2'h2, 1'b0, 1'b0, 8'h01);
    repeat (4) tick;
    chk_bit(tsc_oe_n, 1'b1);
    chk_bit(tfs_oe_n, 1'b1);
    chk_bit(config_error, 1'b0);
    push(16'ha5c3);
    tx_valid = 1'b0;
    tick;
    m_sel = 1'b0;
    for (n = 0; n < 20 && sdo_oe_n !== 1'b0; n++) tick;
    chk_bit(sdo_oe_n, 1'b0);
    chk_bit(sdo, 1'b1);
    m_sel = 1'b1;
    for (n = 0; n < 20 && sdo_oe_n !== 1'b1; n++) tick;
    chk_bit(sdo_oe_n, 1'b1);
    // slave transfers with the bench clocking, no delay then delay
    peer_word = 16'h3c96;
    push(16'h6b1d);
    tx_valid = 1'b0;
    repeat (4) tick;
    slave_xfer(16'h3c96, 16'h6b1d);
    cfg = mk(2'h3, 1'b1, 1'b0, 8'h01);
    m_clk = 1'b1;
    push(16'h9e42);
    tx_valid = 1'b0;
    repeat (4) tick;
    slave_xfer(16'h3c96, 16'h9e42);
    cfg = mk(2'h2, 1'b0, 1'b0, 8'h02);
    repeat (3) tick;
    chk_bit(config_error, 1'b1);
    wrap_up;
  end
endmodule : ssp_spi_port_bench
`default_nettype wire
